// file: src/lin_mode_pkg.sv
// Constants, types and state layout for the transceiver mode control block.
// Summary of operation
// [RULE1] Normal mode: tx low drives bus dominant.
// [RULE2] Fail-safe: tx pin outputs local wake source.
// [RULE3] Tx low too long forces driver recessive.
// [RULE4] Driver re-enabled after tx high interval.
// [RULE5] Dominant time-out removable by parameter.
// [RULE6] Normal mode: rx follows bus level.
// [RULE7] Enable high keeps Normal mode, regulator on.
// [RULE8] Enable fall with tx high: Silent.
// [RULE9] Enable fall with tx low: Sleep.
// [RULE10] Sleep chosen if tx falls shortly after.
// [RULE11] Watchdog-disable input switches watchdog off.
// [RULE12] Ignition rising edge debounced before wake.
// [RULE13] Regulator control on in Normal, Fail-safe.
// [RULE14] Reset low on undervoltage or watchdog failure.
// [RULE15] Kick counts only after minimum low time.
// [RULE16] Reset low forces Fail-safe from Normal.
// [RULE17] Silent undervoltage: reset low, Fail-safe.
// [RULE18] Silent/Sleep entry ignores wake pin levels.
// [RULE19] Bus dominant pulse wakes into Fail-safe.
// [RULE20] Sleep: regulator off, reset and rx low.
// [RULE21] Enable high wakes; Normal after reset delay.
// [RULE22] Fail-safe and Silent pin behaviour.
// [RULE23] Power-up: Fail-safe, reset low for delay.
// [RULE24] Local wake pin low pulse wakes device.
// [RULE25] Wake flags cleared on reaching Normal.
// [RULE26] Inputs synchronous, times from clock rate.
`default_nettype none

package lin_mode_pkg;

  // ====================
  // Clock and timing
  // ====================
  localparam int unsigned CLK_HZ         = 100_000_000;  // System clock rate.
  localparam int unsigned DOM_TIMEOUT_US = 6000;         // Dominant time-out, 6 ms.
  localparam int unsigned REACT_NS       = 10_000;       // Re-activation time, 10 us.
  localparam int unsigned MODE_WIN_NS    = 3200;         // Enable-before-tx margin, 3.2 us.
  localparam int unsigned IGN_DEB_US     = 160;          // Ignition debounce time.
  localparam int unsigned RESET_US       = 4000;         // Reset delay, 4 ms.
  localparam int unsigned BUS_WAKE_NS    = 30_000;       // Bus wake filter time.
  localparam int unsigned LOC_WAKE_NS    = 30_000;       // Local wake filter time.
  localparam int unsigned TRIG_MIN_NS    = 1000;         // Minimum kick low time.

  // Least times round up to whole cycles.
  localparam int unsigned DOM_TIMEOUT_CYC = (DOM_TIMEOUT_US * 100 + 0) * (CLK_HZ / 100_000_000);
  localparam int unsigned REACT_CYC       = (REACT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MODE_WIN_CYC    = (MODE_WIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned IGN_DEB_CYC     = IGN_DEB_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESET_CYC       = RESET_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BUS_WAKE_CYC    = (BUS_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LOC_WAKE_CYC    = (LOC_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned TRIG_MIN_CYC    = (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WD_PERIOD_US    = 20_000;      // Watchdog service period.
  localparam int unsigned WD_PERIOD_CYC   = WD_PERIOD_US * (CLK_HZ / 1_000_000);

  localparam int unsigned CNT_W = 24;  // Width of every interval counter.

  // ====================
  // Types
  // ====================
  typedef enum logic [2:0] {
    MODE_FAILSAFE,
    MODE_NORMAL,
    MODE_SILENT,
    MODE_SLEEP
  } op_mode_t;

  // Host-side pin levels that travel together.
  typedef struct packed {
    logic tx_in;
    logic op_enable;
    logic wd_kick_n;
    logic wd_disable;
  } host_pins_t;

  // Pins driven back toward the host.
  typedef struct packed {
    logic rx_out;
    logic tx_out;
    logic tx_oe;
    logic reset_out_n_oe;
    logic ext_reg_on;
  } host_drive_t;

  // State of the top module, apart from reg_on_reg, ign_prev_reg and the wake arming and lock-out flags.
  typedef struct packed {
    op_mode_t         mode;
    logic             en_prev;
    logic [CNT_W-1:0] pend_cnt;      // Counts a pending Silent decision.
    logic             pend;          // Enable fell with tx high; waiting.
    logic [CNT_W-1:0] rst_cnt;       // Reset delay counter.
    logic             wake_flag;     // Wake request shown on rx.
    logic             wake_local;    // Last wake source was local.
    logic [CNT_W-1:0] wd_cnt;        // Watchdog period counter.
    logic             wd_fail;       // Watchdog failure seen.
    host_drive_t      pins;          // Registered outputs.
    logic             bus_drive;     // Registered bus driver enable.
  } top_state_t;

endpackage : lin_mode_pkg

`default_nettype wire

// file: src/lin_pulse_filter.sv
// Level filter: reports a qualified pulse or level after a minimum hold time.
`default_nettype none

module lin_pulse_filter #(
  parameter int unsigned CNT_W = 24,
  parameter int unsigned HOLD  = 10
) (
  input  wire logic clk_sys_i,     // System clock.
  input  wire logic nrst_i,        // Asynchronous reset, active low.
  input  wire logic active_i,      // Level being timed.
  input  wire logic clear_i,       // Restart the timer.
  output logic      held_o,        // Level held longer than HOLD cycles.
  output logic      release_o      // One-cycle pulse: level ended after being held.
);

  // ====================
  // Hold timer
  // ====================
  logic [CNT_W-1:0] cnt_reg;  // Cycles the level has stood.
  logic             held_reg; // Hold time reached.
  logic             rel_reg;  // Release pulse.

  assign held_o    = held_reg;
  assign release_o = rel_reg;

  // The counter saturates so long levels never wrap back to zero.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg  <= '0;
      held_reg <= 1'b0;
      rel_reg  <= 1'b0;
    end else begin
      rel_reg <= 1'b0;
      if (clear_i || !active_i) begin
        // A held level that ends marks a complete qualified pulse.
        rel_reg  <= held_reg && !clear_i;
        cnt_reg  <= '0;
        held_reg <= 1'b0;
      end else if (cnt_reg >= CNT_W'(HOLD)) begin
        held_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

endmodule // lin_pulse_filter

`default_nettype wire

// file: src/lin_mode_ctrl.sv
// Mode, wake and pin control of a single-wire bus transceiver.
`default_nettype none

module lin_mode_ctrl #(
  parameter bit          DOM_TIMEOUT_EN = 1'b1,                          // Zero removes the time-out.
  parameter int unsigned DOM_TIMEOUT    = lin_mode_pkg::DOM_TIMEOUT_CYC, // Dominant time-out cycles.
  parameter int unsigned RESET_DELAY    = lin_mode_pkg::RESET_CYC,       // Reset delay cycles.
  parameter int unsigned WD_PERIOD      = lin_mode_pkg::WD_PERIOD_CYC    // Watchdog period cycles.
) (
  input  wire logic clk_sys_i,         // System clock, 100 MHz.
  input  wire logic nrst_i,            // Asynchronous reset, active low.
  input  wire logic tx_in_i,           // Transmit pin level from host.
  input  wire logic op_enable_i,       // Mode enable from host.
  input  wire logic wd_kick_n_i,       // Watchdog trigger, active low.
  input  wire logic wd_disable_i,      // High turns watchdog off.
  input  wire logic ignition_in_i,     // Ignition wake input.
  input  wire logic wake_n_i,          // Local wake pin, active low.
  input  wire logic bus_i,             // Bus level, high is recessive.
  input  wire logic undervolt_i,       // Regulated supply undervoltage.
  output logic      bus_drive_o,       // High pulls the bus dominant.
  output logic      rx_out_o,          // Receive pin level.
  output logic      tx_out_o,          // Tx pin level when driven.
  output logic      tx_oe_o,           // Tx pin output enable.
  output logic      reset_out_n_oe_o,  // High pulls reset_out_n low.
  output logic      ext_reg_on_o,      // External regulator control.
  output logic      reg_on_o,          // Internal regulator enable.
  output lin_mode_pkg::op_mode_t mode_o // Current operating mode.
);

  import lin_mode_pkg::*;

  // ====================
  // Signals
  // ====================
  top_state_t st_reg;    // Registered state.
  top_state_t st_next;   // Next state.
  logic       reg_on_reg;// Registered regulator enable.
  logic       reg_on_next;
  host_pins_t hp;        // Host pin bundle.

  logic dom_held, dom_clr;       // Dominant time-out timer.
  logic rec_held;                // Re-activation timer.
  logic timed_out_reg;           // Driver locked out after time-out.
  logic ign_held, ign_prev_reg;  // Ignition debounce.
  logic ign_armed_reg;           // Ignition seen low since last wake.
  logic loc_held, loc_armed_reg; // Local wake filter.
  logic bus_rel;                 // Qualified bus dominant pulse ended.
  logic kick_rel;                // Qualified kick.

  assign hp = '{tx_in: tx_in_i, op_enable: op_enable_i, wd_kick_n: wd_kick_n_i, wd_disable: wd_disable_i};

  // ====================
  // Interval filters
  // ====================
  // [RULE3] dominant time-out timer
  lin_pulse_filter #(.CNT_W(CNT_W), .HOLD(DOM_TIMEOUT)) u_dom (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .active_i  (!hp.tx_in && st_reg.mode == MODE_NORMAL),
    .clear_i   (dom_clr),
    .held_o    (dom_held),
    .release_o ()
  );
  assign dom_clr = 1'b0;

  // [RULE4] re-activation high time
  lin_pulse_filter #(.CNT_W(CNT_W), .HOLD(REACT_CYC)) u_rec (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .active_i  (hp.tx_in),
    .clear_i   (1'b0),
    .held_o    (rec_held),
    .release_o ()
  );

  // [RULE12] ignition debounce timer
  lin_pulse_filter #(.CNT_W(CNT_W), .HOLD(IGN_DEB_CYC)) u_ign (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .active_i  (ignition_in_i && ign_armed_reg),
    .clear_i   (1'b0),
    .held_o    (ign_held),
    .release_o ()
  );

  // [RULE24] local wake filter
  lin_pulse_filter #(.CNT_W(CNT_W), .HOLD(LOC_WAKE_CYC)) u_loc (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .active_i  (!wake_n_i && loc_armed_reg),
    .clear_i   (1'b0),
    .held_o    (loc_held),
    .release_o ()
  );

  // [RULE19] bus dominant pulse filter
  lin_pulse_filter #(.CNT_W(CNT_W), .HOLD(BUS_WAKE_CYC)) u_bus (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .active_i  (!bus_i),
    .clear_i   (1'b0),
    .held_o    (),
    .release_o (bus_rel)
  );

  // [RULE15] kick minimum low time
  lin_pulse_filter #(.CNT_W(CNT_W), .HOLD(TRIG_MIN_CYC)) u_kick (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .active_i  (!hp.wd_kick_n),
    .clear_i   (1'b0),
    .held_o    (),
    .release_o (kick_rel)
  );

  // ====================
  // Edge arming for level-held wake inputs
  // ====================
  // Wake pins are edge sensitive: a level that was already active when the
  // device went quiet must first go inactive before it may wake it again.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ign_prev_reg  <= 1'b0;
      ign_armed_reg <= 1'b0;
      loc_armed_reg <= 1'b0;
      timed_out_reg <= 1'b0;
    end else begin
      ign_prev_reg <= ignition_in_i;
      // [RULE12] arm on low, disarm after use
      if (!ignition_in_i) begin
        ign_armed_reg <= 1'b1;
      end else if (ign_held) begin
        ign_armed_reg <= 1'b0;
      end
      if (wake_n_i) begin
        loc_armed_reg <= 1'b1;
      end else if (loc_held) begin
        loc_armed_reg <= 1'b0;
      end
      // [RULE3] lock out, [RULE4] release
      if (DOM_TIMEOUT_EN && dom_held) begin
        timed_out_reg <= 1'b1;
      end else if (rec_held) begin
        timed_out_reg <= 1'b0;
      end
    end
  end

  // ====================
  // Mode sequencer and outputs
  // ====================
  // One process computes st_next and reg_on_next; every output is registered.
  always_comb begin
    logic en_fall;
    logic rst_low;
    logic wake_ev;
    logic loc_ev;
    logic wd_on;
    en_fall = 1'b0;
    rst_low = 1'b0;
    wake_ev = 1'b0;
    loc_ev  = 1'b0;
    wd_on   = 1'b0;
    st_next = st_reg;
    reg_on_next = reg_on_reg;
    en_fall = st_reg.en_prev && !hp.op_enable;
    st_next.en_prev = hp.op_enable;
    // [RULE24] [RULE12] local wake sources
    loc_ev  = (loc_held && loc_armed_reg) || (ign_held && ign_armed_reg);
    // [RULE19] remote wake source
    wake_ev = loc_ev || bus_rel;

    // [RULE11] watchdog disable input
    wd_on = !hp.wd_disable && (st_reg.mode == MODE_NORMAL || st_reg.mode == MODE_FAILSAFE);
    if (!wd_on || kick_rel) begin
      st_next.wd_cnt = '0;
    end else if (st_reg.wd_cnt >= CNT_W'(WD_PERIOD)) begin
      st_next.wd_fail = 1'b1;
      st_next.wd_cnt  = '0;
    end else begin
      st_next.wd_cnt = st_reg.wd_cnt + CNT_W'(1);
    end

    // Reset delay counts down while the reset pin is held low.
    if (st_reg.rst_cnt != '0) begin
      st_next.rst_cnt = st_reg.rst_cnt - CNT_W'(1);
    end else begin
      // A failure stands one cycle; its fresh reset delay then holds the pin low.
      st_next.wd_fail = st_next.wd_fail && !st_reg.wd_fail;
    end
    if (st_reg.wd_fail && st_reg.rst_cnt == '0 && !(st_reg.mode == MODE_SLEEP)) begin
      st_next.rst_cnt = CNT_W'(RESET_DELAY);
    end

    case (st_reg.mode)
      MODE_NORMAL: begin
        // [RULE8] [RULE9] [RULE10] mode select on enable fall
        if (en_fall && !hp.tx_in) begin
          st_next.mode = MODE_SLEEP;
        end else if (en_fall) begin
          st_next.pend     = 1'b1;
          st_next.pend_cnt = CNT_W'(MODE_WIN_CYC);
        end
        // [RULE16] reset low leaves Normal
        if (undervolt_i || st_next.wd_fail || st_reg.rst_cnt != '0) begin
          st_next.mode = MODE_FAILSAFE;
          st_next.pend = 1'b0;
        end
        // [RULE25] wake flags cleared in Normal
        st_next.wake_flag  = 1'b0;
        st_next.wake_local = 1'b0;
      end
      MODE_SILENT, MODE_SLEEP: begin
        // [RULE21] enable high wakes
        if (hp.op_enable || wake_ev) begin
          st_next.mode = MODE_FAILSAFE;
          st_next.rst_cnt = CNT_W'(RESET_DELAY);
          // [RULE19] [RULE24] record wake request and source
          if (wake_ev) begin
            st_next.wake_flag  = 1'b1;
            st_next.wake_local = loc_ev;
          end
        end else if (st_reg.mode == MODE_SILENT && undervolt_i) begin
          // [RULE17] undervoltage in Silent
          st_next.mode    = MODE_FAILSAFE;
          st_next.rst_cnt = CNT_W'(RESET_DELAY);
        end
        st_next.wd_fail = 1'b0;
      end
      default: begin
        // [RULE21] [RULE23] Normal after reset delay
        if (hp.op_enable && st_reg.rst_cnt == '0 && !undervolt_i && !st_reg.wd_fail && !st_next.wd_fail) begin
          st_next.mode = MODE_NORMAL;
        end
      end
    endcase

    // [RULE10] tx low in any cycle of the window selects Sleep
    if (st_reg.pend) begin
      if (!hp.tx_in) begin
        st_next.mode = MODE_SLEEP;
        st_next.pend = 1'b0;
      end else if (st_reg.pend_cnt == '0) begin
        // [RULE8] [RULE18] Silent regardless of wake pins
        st_next.mode = MODE_SILENT;
        st_next.pend = 1'b0;
      end else begin
        st_next.pend_cnt = st_reg.pend_cnt - CNT_W'(1);
      end
      if (st_next.mode == MODE_FAILSAFE) begin
        st_next.pend = 1'b0;
      end
    end

    // Pin outputs follow the next mode so they change with it.
    // [RULE1] [RULE3] [RULE5] bus driver gating
    st_next.bus_drive = st_next.mode == MODE_NORMAL && !st_next.pend && !hp.tx_in && !timed_out_reg
                        && !(DOM_TIMEOUT_EN && dom_held);
    case (st_next.mode)
      // [RULE6] rx follows bus
      MODE_NORMAL: st_next.pins.rx_out = bus_i;
      // [RULE20] rx low in Sleep
      MODE_SLEEP:  st_next.pins.rx_out = 1'b0;
      // [RULE22] Silent high, Fail-safe flags wake
      MODE_SILENT: st_next.pins.rx_out = 1'b1;
      default:     st_next.pins.rx_out = !st_next.wake_flag;
    endcase
    // [RULE2] tx pin reports wake source
    st_next.pins.tx_oe  = st_next.mode == MODE_FAILSAFE;
    st_next.pins.tx_out = !st_next.wake_local;
    // [RULE14] [RULE20] [RULE23] reset pin
    st_next.pins.reset_out_n_oe = undervolt_i || st_next.rst_cnt != '0 || st_next.wd_fail
                                  || st_next.mode == MODE_SLEEP;
    // [RULE7] [RULE13] regulator controls
    st_next.pins.ext_reg_on = (st_next.mode == MODE_NORMAL || st_next.mode == MODE_FAILSAFE)
                              && !undervolt_i;
    reg_on_next = st_next.mode != MODE_SLEEP;
  end

  // [RULE23] [RULE26] power-up state
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg         <= '0;
      st_reg.mode    <= MODE_FAILSAFE;
      st_reg.rst_cnt <= CNT_W'(RESET_DELAY);
      st_reg.pins    <= '{rx_out: 1'b1, tx_out: 1'b1, tx_oe: 1'b1, reset_out_n_oe: 1'b1, ext_reg_on: 1'b1};
      reg_on_reg     <= 1'b1;
    end else begin
      st_reg     <= st_next;
      reg_on_reg <= reg_on_next;
    end
  end

  assign bus_drive_o      = st_reg.bus_drive;
  assign rx_out_o         = st_reg.pins.rx_out;
  assign tx_out_o         = st_reg.pins.tx_out;
  assign tx_oe_o          = st_reg.pins.tx_oe;
  assign reset_out_n_oe_o = st_reg.pins.reset_out_n_oe;
  assign ext_reg_on_o     = st_reg.pins.ext_reg_on;
  assign reg_on_o         = reg_on_reg;
  assign mode_o           = st_reg.mode;

endmodule // lin_mode_ctrl

`default_nettype wire

// file: bench/host_kick_model.sv
// Host-side model that services the watchdog trigger pin.
`default_nettype none

module host_kick_model #(
  parameter int unsigned LOW_CYC = 110,  // Low time of one kick.
  parameter int unsigned GAP_CYC = 150   // Kick period.
) (
  input  wire logic clk_sys_i,    // System clock.
  input  wire logic kick_en_i,    // High while the host keeps kicking.
  output logic      wd_kick_n_o   // Trigger pin, driven high while kicking is off.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Kick generator
  // ====================
  int unsigned cnt;  // Position inside the kick period.
  initial begin
    cnt = 0;
    wd_kick_n_o = 1'b1;
  end
  always @(posedge clk_sys_i) begin
    if (!kick_en_i) begin
      cnt <= 0;
      wd_kick_n_o <= 1'b1;
    end else begin
      cnt <= (cnt == GAP_CYC - 1) ? 0 : cnt + 1;
      wd_kick_n_o <= (cnt >= LOW_CYC);
    end
  end
endmodule // host_kick_model

`default_nettype wire

// file: bench/lin_mode_ctrl_assertions.sv
// Concurrent checks on the mode control ports.
`default_nettype none

module lin_mode_ctrl_assertions #(
  parameter bit          DOM_TIMEOUT_EN = 1'b1,  // Zero means no time-out.
  parameter int unsigned DOM_TIMEOUT    = 50     // Time-out in cycles.
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic tx_in_i,
  input wire logic op_enable_i,
  input wire logic bus_i,
  input wire logic undervolt_i,
  input wire logic bus_drive_o,
  input wire logic rx_out_o,
  input wire logic tx_oe_o,
  input wire logic reset_out_n_oe_o,
  input wire logic ext_reg_on_o,
  input wire logic reg_on_o,
  input var lin_mode_pkg::op_mode_t mode_o
);
  import lin_mode_pkg::*;
  // ====================
  // Helper counter
  // ====================
  logic [19:0] low_cnt_reg;  // Tx low run in Normal, saturating.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt_reg <= '0;
    end else if (mode_o != MODE_NORMAL || tx_in_i) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + 20'h1;
    end
  end
  // ====================
  // Properties
  // ====================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_tx_high_recessive: assert property (mode_o == MODE_NORMAL && tx_in_i |=> !bus_drive_o)
    else $error("tx high drove bus");
  a_drive_only_normal: assert property (mode_o != MODE_NORMAL |-> !bus_drive_o)
    else $error("bus driven outside Normal");
  a_dom_time_out: assert property (DOM_TIMEOUT_EN && low_cnt_reg > 20'(DOM_TIMEOUT + 2) |-> !bus_drive_o)
    else $error("no time-out");
  a_rx_follows_bus: assert property (mode_o == MODE_NORMAL && $past(mode_o) == MODE_NORMAL
    |-> rx_out_o == $past(bus_i))
    else $error("rx not bus");
  a_sleep_entry: assert property ($fell(op_enable_i) && !tx_in_i && mode_o == MODE_NORMAL
    |-> ##[1:3] mode_o == MODE_SLEEP)
    else $error("sleep not entered");
  a_silent_leave: assert property ($fell(op_enable_i) && tx_in_i && mode_o == MODE_NORMAL
    |-> ##[1:340] mode_o != MODE_NORMAL)
    else $error("normal not left");
  a_sleep_pins: assert property (mode_o == MODE_SLEEP
    |-> !reg_on_o && !rx_out_o && reset_out_n_oe_o && !ext_reg_on_o)
    else $error("sleep pins");
  a_regctl_off: assert property (mode_o == MODE_SILENT || mode_o == MODE_SLEEP |-> !ext_reg_on_o)
    else $error("regulator on");
  a_uv_reset: assert property (undervolt_i |=> reset_out_n_oe_o && !ext_reg_on_o)
    else $error("undervoltage missed");
  a_reset_not_normal: assert property (reset_out_n_oe_o |-> mode_o != MODE_NORMAL)
    else $error("normal mode while reset low");
  a_silent_uv: assert property (mode_o == MODE_SILENT && undervolt_i |-> ##[1:3] mode_o == MODE_FAILSAFE)
    else $error("silent undervoltage");
  a_silent_rx: assert property (mode_o == MODE_SILENT |-> rx_out_o)
    else $error("rx low in silent");
  a_enable_wake: assert property (mode_o == MODE_SLEEP && op_enable_i |-> ##[1:3] mode_o == MODE_FAILSAFE)
    else $error("enable did not wake");
  a_normal_tx_input: assert property (mode_o == MODE_NORMAL |-> !tx_oe_o)
    else $error("tx pin driven in Normal");
  c_sleep: cover property (mode_o == MODE_SLEEP);
  c_silent: cover property (mode_o == MODE_SILENT);
  c_timeout: cover property (low_cnt_reg > 20'(DOM_TIMEOUT + 2));
endmodule // lin_mode_ctrl_assertions

bind lin_mode_ctrl lin_mode_ctrl_assertions #(.DOM_TIMEOUT_EN(DOM_TIMEOUT_EN), .DOM_TIMEOUT(DOM_TIMEOUT)) u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tx_in_i(tx_in_i), .op_enable_i(op_enable_i), .bus_i(bus_i),
  .undervolt_i(undervolt_i), .bus_drive_o(bus_drive_o), .rx_out_o(rx_out_o), .tx_oe_o(tx_oe_o),
  .reset_out_n_oe_o(reset_out_n_oe_o), .ext_reg_on_o(ext_reg_on_o), .reg_on_o(reg_on_o), .mode_o(mode_o));

`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the transceiver mode control block.
`default_nettype none

`define CHECK(name, exp, got) begin num_checks++; if ((exp) !== (got)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", name, exp, got); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lin_mode_pkg::*;
  localparam int DT = 50, RD = 20, WP = 200;  // Shortened counts.
  // ====================
  // Signals
  // ====================
  logic clk_sys_i, nrst_i, tx, en, wdd, ign, wake_n, uv, remote_dom, kick_en;
  logic kick_n, drive, drive2, rx, tx_out, tx_oe, rst_oe, ext_reg, reg_on, bus;
  op_mode_t mode;
  int error_cnt = 0, num_checks = 0;
  logic [31:0] rng = 32'hF137;
  typedef struct packed {logic [10:0] val; logic [10:0] mask;} note_t;
  note_t notes[$], cur;
  event chk_ev;
  wire [10:0] obs = {mode, drive2, drive, rx, tx_out, tx_oe, rst_oe, ext_reg, reg_on};
  assign bus = !(drive || remote_dom);

  always #5 clk_sys_i = ~clk_sys_i;

  lin_mode_ctrl #(.DOM_TIMEOUT(DT), .RESET_DELAY(RD), .WD_PERIOD(WP)) DUT (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tx_in_i(tx), .op_enable_i(en), .wd_kick_n_i(kick_n),
    .wd_disable_i(wdd), .ignition_in_i(ign), .wake_n_i(wake_n), .bus_i(bus), .undervolt_i(uv),
    .bus_drive_o(drive), .rx_out_o(rx), .tx_out_o(tx_out), .tx_oe_o(tx_oe), .reset_out_n_oe_o(rst_oe),
    .ext_reg_on_o(ext_reg), .reg_on_o(reg_on), .mode_o(mode));
  lin_mode_ctrl #(.DOM_TIMEOUT_EN(1'b0), .DOM_TIMEOUT(DT), .RESET_DELAY(RD), .WD_PERIOD(WP)) DUT2 (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tx_in_i(tx), .op_enable_i(en), .wd_kick_n_i(kick_n),
    .wd_disable_i(wdd), .ignition_in_i(ign), .wake_n_i(wake_n), .bus_i(bus), .undervolt_i(uv),
    .bus_drive_o(drive2), .rx_out_o(), .tx_out_o(), .tx_oe_o(), .reset_out_n_oe_o(),
    .ext_reg_on_o(), .reg_on_o(), .mode_o());
  host_kick_model u_host (.clk_sys_i(clk_sys_i), .kick_en_i(kick_en), .wd_kick_n_o(kick_n));
  // ====================
  // Helpers
  // ====================
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Bounded mode wait, then pins settle.
  task automatic wait_mode(input op_mode_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(posedge clk_sys_i);
    cyc(2);
  endtask
  // Queues a note off the edge.
  task automatic note(input op_mode_t m, input logic [7:0] v, input logic [7:0] mk);
    @(negedge clk_sys_i);
    notes.push_back({m, v, 3'h7, mk});
    ->chk_ev;
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compares the oldest note under its mask.
  always begin
    @(chk_ev);
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      `CHECK("pins", cur.val & cur.mask, obs & cur.mask)
    end
  end
  // Hang guard, nearly four times the run.
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    error_cnt++;
    report_and_stop();
  end
  // ====================
  // Scenarios
  // ====================
  initial begin
    clk_sys_i = 1'b0;
    nrst_i = 1'b0;
    {tx, en, wdd, ign, wake_n, uv, remote_dom, kick_en} = 8'hA8;
    cyc(3);
    note(MODE_FAILSAFE, 8'h3F, 8'hFF);
    cyc(7);
    nrst_i <= 1'b1;
    cyc(RD + 5);
    note(MODE_FAILSAFE, 8'h23, 8'h67);
    en <= 1'b1;
    wait_mode(MODE_NORMAL, RD + 10);
    note(MODE_NORMAL, 8'h23, 8'hEF);
    repeat (12) begin
      rng = xs(rng);
      @(posedge clk_sys_i) tx <= rng[0];
      cyc(2);
      note(MODE_NORMAL, {~rng[0], ~rng[0], rng[0], 5'h03}, 8'hEF);
    end
    @(posedge clk_sys_i) tx <= 1'b0;
    cyc(DT + 5);
    note(MODE_NORMAL, 8'h80, 8'hC0);
    tx <= 1'b1;
    cyc(REACT_CYC - 100);
    tx <= 1'b0;
    cyc(3);
    note(MODE_NORMAL, 8'h00, 8'h40);
    tx <= 1'b1;
    cyc(REACT_CYC + 10);
    tx <= 1'b0;
    cyc(3);
    note(MODE_NORMAL, 8'h40, 8'h40);
    tx <= 1'b1;
    cyc(5);
    en <= 1'b0;
    wait_mode(MODE_SILENT, MODE_WIN_CYC + 40);
    note(MODE_SILENT, 8'h21, 8'h67);
    uv <= 1'b1;
    cyc(3);
    note(MODE_FAILSAFE, 8'h04, 8'h06);
    uv <= 1'b0;
    en <= 1'b1;
    wait_mode(MODE_NORMAL, RD + 20);
    en <= 1'b0;
    cyc(100);
    tx <= 1'b0;
    wait_mode(MODE_SLEEP, MODE_WIN_CYC + 40);
    note(MODE_SLEEP, 8'h04, 8'h67);
    tx <= 1'b1;
    remote_dom <= 1'b1;
    cyc(BUS_WAKE_CYC + 50);
    remote_dom <= 1'b0;
    wait_mode(MODE_FAILSAFE, 20);
    note(MODE_FAILSAFE, 8'h1B, 8'h7B);
    en <= 1'b1;
    wait_mode(MODE_NORMAL, RD + 20);
    note(MODE_NORMAL, 8'h23, 8'hEF);
    for (int k = 0; k < 2; k++) begin
      en <= 1'b0;
      tx <= k[0];
      wait_mode(k ? MODE_SILENT : MODE_SLEEP, MODE_WIN_CYC + 40);
      tx <= 1'b1;
      if (k) ign <= 1'b1;
      else wake_n <= 1'b0;
      wait_mode(MODE_FAILSAFE, (k ? IGN_DEB_CYC : LOC_WAKE_CYC) + 50);
      note(MODE_FAILSAFE, 8'h0B, 8'h7B);
      ign <= 1'b0;
      wake_n <= 1'b1;
      en <= 1'b1;
      wait_mode(MODE_NORMAL, RD + 20);
      note(MODE_NORMAL, 8'h23, 8'hEF);
    end
    wdd <= 1'b0;
    kick_en <= 1'b1;
    cyc(4 * WP);
    note(MODE_NORMAL, 8'h23, 8'h67);
    kick_en <= 1'b0;
    wait_mode(MODE_FAILSAFE, 2 * WP);
    note(MODE_FAILSAFE, 8'h04, 8'h04);
    wdd <= 1'b1;
    wait_mode(MODE_NORMAL, 3 * WP);
    cyc(3 * WP);
    note(MODE_NORMAL, 8'h23, 8'h67);
    cyc(2);
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
